//--- sram_host.sv
// Host controller that drives an asynchronous 64K x 16 static memory
`timescale 1ns/1ns
// Overview of operation
// - Write drives select and write strobe low
// - Read drives select and output enable low
// - Hold write data around the ending edge
// - Address valid before output enable falls
// - Byte select low at least 9 ns
module sram_host
  import sram_host_pkg::*;
#(
  parameter int write_wait = write_cycles,
  parameter int read_wait  = read_cycles,
  parameter int turn_wait  = turn_cycles
) (
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  input  wire logic                       clock_enable,
  input  wire logic                       request_valid,
  input  wire logic                       request_write,
  input  wire sram_host_pkg::addr_type    request_address,
  input  wire sram_host_pkg::data_type    request_data,
  input  wire sram_host_pkg::byte_en_type request_bytes,
  output logic                            request_ready,
  output logic                            read_valid,
  output sram_host_pkg::data_type         read_data,
  output sram_host_pkg::addr_type         mem_address,
  output logic                            chip_select_n,
  output logic                            write_strobe_n,
  output logic                            output_drive_n,
  output logic                            low_byte_sel_n,
  output logic                            high_byte_sel_n,
  input  wire sram_host_pkg::data_type    mem_data_in,
  output sram_host_pkg::data_type         mem_data_out,
  output logic                            mem_data_oe
);
  import sram_host_pkg::*;

  // Largest count the phase timer can hold
  localparam int max_wait = (1 << count_width) - 1;

  // Counts must fit the counter, cover byte time and read access
  if (write_wait < 1 || write_wait < byte_write_cycles ||
      write_wait > max_wait || read_wait < 1 ||
      read_wait < read_cycles || read_wait > max_wait ||
      turn_wait < 1 || turn_wait > max_wait)
  begin : g_bad_wait
    $error("sram_host: wait counts out of range");
  end

  localparam logic [count_width-1:0] write_load =
    count_width'(write_wait - 1);
  localparam logic [count_width-1:0] read_load =
    count_width'(read_wait - 1);
  localparam logic [count_width-1:0] turn_load =
    count_width'(turn_wait - 1);

  typedef enum logic [5:0] {
    idle_state   = 6'h01,
    setup_state  = 6'h02,
    write_state  = 6'h04,
    finish_state = 6'h08,
    read_state   = 6'h10,
    turn_state   = 6'h20
  } phase_type;

  typedef struct packed {
    phase_type   phase;
    logic        ready;
    logic        rvalid;
    data_type    rdata;
    addr_type    address;
    logic        cs_n;
    logic        we_n;
    logic        oe_n;
    logic        lb_n;
    logic        hb_n;
    data_type    wdata;
    logic        drive;
    logic        is_write;
    byte_en_type bytes;
  } state_type;

  state_type state;
  state_type next_state;
  logic      timer_load;
  logic [count_width-1:0] timer_value;
  logic      timer_done;

  sram_wait_counter #(.width(count_width)) phase_timer (
    .clock      (clock),
    .rst_n      (rst_n),
    .enable     (clock_enable),
    .load       (timer_load),
    .load_value (timer_value),
    .done       (timer_done)
  );

  // Sequencer: address settles first, then one strobe phase
  always_comb
  begin
    next_state = state;
    timer_load = 1'b0;
    timer_value = count_zero;
    next_state.rvalid = 1'b0;
    case (state.phase)
      idle_state:
      begin
        // Deselected: bus released, memory in standby
        next_state.cs_n = 1'b1;
        next_state.ready = 1'b1;
        if (request_valid && state.ready && request_bytes != no_bytes)
        begin
          next_state.ready = 1'b0;
          next_state.address = request_address;
          next_state.wdata = request_data;
          next_state.is_write = request_write;
          next_state.bytes = request_bytes;
          next_state.phase = setup_state;
        end
      end
      setup_state:
      begin
        // Address already stable before any strobe falls
        next_state.cs_n = 1'b0;
        next_state.lb_n = ~state.bytes[0];
        next_state.hb_n = ~state.bytes[1];
        if (state.is_write)
        begin
          // Output enable high during writes, so we own the bus
          next_state.oe_n = 1'b1;
          next_state.we_n = 1'b0;
          next_state.drive = 1'b1;
          timer_load = 1'b1;
          timer_value = write_load;
          next_state.phase = write_state;
        end
        else
        begin
          // Drivers already off since idle; address set before oe
          next_state.oe_n = 1'b0;
          next_state.we_n = 1'b1;
          next_state.drive = 1'b0;
          timer_load = 1'b1;
          timer_value = read_load;
          next_state.phase = read_state;
        end
      end
      write_state:
      begin
        if (timer_done)
        begin
          // Only write strobe rises; select stays low one cycle
          next_state.we_n = 1'b1;
          next_state.phase = finish_state;
        end
      end
      finish_state:
      begin
        // Data held past the strobe rise, then released
        next_state.drive = 1'b0;
        next_state.cs_n = 1'b1;
        next_state.lb_n = 1'b1;
        next_state.hb_n = 1'b1;
        next_state.ready = 1'b1;
        next_state.phase = idle_state;
      end
      read_state:
      begin
        if (timer_done)
        begin
          // Unselected lanes read as zero, they float at the memory
          next_state.rdata = mem_data_in &
            {{byte_width{state.bytes[1]}},
             {byte_width{state.bytes[0]}}};
          next_state.rvalid = 1'b1;
          next_state.oe_n = 1'b1;
          next_state.cs_n = 1'b1;
          next_state.lb_n = 1'b1;
          next_state.hb_n = 1'b1;
          timer_load = 1'b1;
          timer_value = turn_load;
          next_state.phase = turn_state;
        end
      end
      turn_state:
      begin
        // Wait for memory to float before a write may drive
        if (timer_done)
        begin
          next_state.ready = 1'b1;
          next_state.phase = idle_state;
        end
      end
      default:
      begin
        next_state.phase = idle_state;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state.phase <= idle_state;
      state.ready <= 1'b0;
      state.rvalid <= 1'b0;
      state.rdata <= data_zero;
      state.address <= addr_zero;
      state.cs_n <= 1'b1;
      state.we_n <= 1'b1;
      state.oe_n <= 1'b1;
      state.lb_n <= 1'b1;
      state.hb_n <= 1'b1;
      state.wdata <= data_zero;
      state.drive <= 1'b0;
      state.is_write <= 1'b0;
      state.bytes <= no_bytes;
    end
    else if (clock_enable)
      state <= next_state;
  end

  assign request_ready = state.ready;
  assign read_valid = state.rvalid;
  assign read_data = state.rdata;
  assign mem_address = state.address;
  assign chip_select_n = state.cs_n;
  assign write_strobe_n = state.we_n;
  assign output_drive_n = state.oe_n;
  assign low_byte_sel_n = state.lb_n;
  assign high_byte_sel_n = state.hb_n;
  assign mem_data_out = state.wdata;
  assign mem_data_oe = state.drive;
endmodule // sram_host

//--- sram_host_pkg.sv
// Package with constants and types for the static memory host controller
package sram_host_pkg;
  localparam int addr_width = 16;
  localparam int data_width = 16;
  localparam int byte_width = 8;
  localparam int clock_period_ns = 10;
  // Least byte-select-low time before write end, slowest grade
  localparam int byte_write_ns = 9;
  // Least write pulse and read access, slowest grade
  localparam int write_pulse_ns = 10;
  localparam int read_access_ns = 15;
  // Bus turnaround after output disable (high-Z time, slowest grade)
  localparam int turnaround_ns = 7;
  localparam int byte_write_cycles =
    (byte_write_ns + clock_period_ns - 1) / clock_period_ns;
  localparam int write_pulse_raw =
    (write_pulse_ns + clock_period_ns - 1) / clock_period_ns;
  localparam int write_cycles = (write_pulse_raw > byte_write_cycles) ?
    write_pulse_raw : byte_write_cycles;
  localparam int read_cycles =
    (read_access_ns + clock_period_ns - 1) / clock_period_ns;
  localparam int turn_cycles =
    (turnaround_ns + clock_period_ns - 1) / clock_period_ns;
  localparam int count_width = 4;
  localparam logic [count_width-1:0] count_zero = 4'h0;
  localparam logic [count_width-1:0] count_one = 4'h1;
  typedef logic [addr_width-1:0] addr_type;
  typedef logic [data_width-1:0] data_type;
  typedef logic [1:0] byte_en_type;
  localparam byte_en_type no_bytes = 2'h0;
  localparam data_type data_zero = 16'h0000;
  localparam addr_type addr_zero = 16'h0000;
endpackage

//--- sram_wait_counter.sv
// Small down counter that times the write, read and turnaround bus phases
`timescale 1ns/1ns
module sram_wait_counter #(
  parameter int width = 4
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             enable,
  input  wire logic             load,
  input  wire logic [width-1:0] load_value,
  output logic                  done
);
  logic [width-1:0] count;
  logic [width-1:0] next_count;

  // Load wins over counting; stops at zero
  always_comb
  begin
    next_count = count;
    if (load)
      next_count = load_value;
    else if (count != '0)
      next_count = count - width'(1);
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      count <= '0;
    else if (enable)
      count <= next_count;
  end

  assign done = (count == '0);
endmodule // sram_wait_counter

//--- sram_host_chk.sv
// Checker of the memory bus rules at the host controller ports
`timescale 1ns/1ns
module sram_host_chk
  import sram_host_pkg::*;
(
  input wire logic                    clock,
  input wire logic                    rst_n,
  input wire sram_host_pkg::addr_type mem_address,
  input wire logic                    chip_select_n,
  input wire logic                    write_strobe_n,
  input wire logic                    output_drive_n,
  input wire logic                    low_byte_sel_n,
  input wire logic                    high_byte_sel_n,
  input wire sram_host_pkg::data_type mem_data_out,
  input wire logic                    mem_data_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Strobe only to a selected part
  chk_strobe_sel: assert property (!write_strobe_n |-> !chip_select_n)
    else $error("strobe without select");
  chk_read_ctl: assert property (
    !output_drive_n |-> write_strobe_n && !chip_select_n)
    else $error("bad read controls");
  // Data must survive the strobe's rising edge
  chk_data_hold: assert property (
    !write_strobe_n |=> mem_data_oe && $stable(mem_data_out))
    else $error("write data moved");
  chk_addr_steady: assert property (
    !output_drive_n |-> $stable(mem_address))
    else $error("address moved in read");
  chk_lane_held: assert property (
    !write_strobe_n |-> !(low_byte_sel_n && high_byte_sel_n)
    ##1 $stable({low_byte_sel_n, high_byte_sel_n}))
    else $error("byte select too short");
  chk_no_fight: assert property (mem_data_oe |-> output_drive_n)
    else $error("host drives into read");
  // Main traffic shapes
  cover property (!write_strobe_n && high_byte_sel_n);
  cover property (!output_drive_n && low_byte_sel_n);
  cover property (!output_drive_n ##1 output_drive_n ##[1:20] !write_strobe_n);
endmodule // sram_host_chk
bind sram_host sram_host_chk i_chk (.*);

//--- sram_model.sv
// Behavioural 64K x 16 asynchronous static memory on the far side
`timescale 1ns/1ns
module sram_model
  import sram_host_pkg::*;
#(
  parameter int access_ns = 15
) (
  input  wire logic                    chip_select_n,
  input  wire logic                    write_strobe_n,
  input  wire logic                    output_drive_n,
  input  wire logic                    low_byte_sel_n,
  input  wire logic                    high_byte_sel_n,
  input  wire sram_host_pkg::addr_type address,
  input  wire sram_host_pkg::data_type bus,
  output sram_host_pkg::data_type      drive_data,
  output logic [1:0]                   drive_lanes
);
  data_type   store [0:65535];
  logic       writing;
  logic [1:0] now;
  logic [1:0] late;
  // Deselect blocks everything
  assign writing = !chip_select_n && !write_strobe_n;
  // Store lasts only while all three overlap
  always @*
  begin
    if (writing && !low_byte_sel_n)
      store[address][7:0] = bus[7:0];
    if (writing && !high_byte_sel_n)
      store[address][15:8] = bus[15:8];
  end
  // Turn-on is slow, release is at once
  assign now = (!chip_select_n && !output_drive_n && write_strobe_n) ?
    ~{high_byte_sel_n, low_byte_sel_n} : 2'h0;
  assign #(access_ns) late = now;
  assign drive_lanes = now & late;
  assign #(access_ns) drive_data = store[address];
endmodule // sram_model

//--- sram_host_bench.sv
// Self-checking bench of the static memory host controller
`timescale 1ns/1ns
`define CHECK(what, exp, got) begin checked++; if ((got) !== (exp)) \
  begin failures++; $display("ERROR %s %h %h", what, exp, got); end end
module sram_host_bench;
  import sram_host_pkg::*;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        clock_enable = 1'b1;
  logic        request_valid = 1'b0;
  logic        request_write = 1'b0;
  addr_type    request_address = 16'h0000;
  data_type    request_data = 16'h0000;
  byte_en_type request_bytes = 2'h0;
  logic        request_ready, read_valid, mem_data_oe;
  logic        chip_select_n, write_strobe_n, output_drive_n;
  logic        low_byte_sel_n, high_byte_sel_n;
  data_type    read_data, mem_data_in, mem_data_out, drive_data;
  data_type    float_pat = 16'h5a5a;
  addr_type    mem_address;
  logic [1:0]  drive_lanes;
  data_type    shadow [0:65535];
  int          failures = 0;
  int          checked = 0;
  sram_host i_dut (
    .clock           (clock),
    .rst_n           (rst_n),
    .clock_enable    (clock_enable),
    .request_valid   (request_valid),
    .request_write   (request_write),
    .request_address (request_address),
    .request_data    (request_data),
    .request_bytes   (request_bytes),
    .request_ready   (request_ready),
    .read_valid      (read_valid),
    .read_data       (read_data),
    .mem_address     (mem_address),
    .chip_select_n   (chip_select_n),
    .write_strobe_n  (write_strobe_n),
    .output_drive_n  (output_drive_n),
    .low_byte_sel_n  (low_byte_sel_n),
    .high_byte_sel_n (high_byte_sel_n),
    .mem_data_in     (mem_data_in),
    .mem_data_out    (mem_data_out),
    .mem_data_oe     (mem_data_oe)
  );
  sram_model i_mem (.chip_select_n, .write_strobe_n, .output_drive_n,
    .low_byte_sel_n, .high_byte_sel_n, .address(mem_address),
    .bus(mem_data_in), .drive_data, .drive_lanes);
  // Floated lanes wander so no stale value passes
  for (genvar i = 0; i < 2; i++)
  begin : g_lane
    assign mem_data_in[i*8 +: 8] = mem_data_oe ? mem_data_out[i*8 +: 8] :
      drive_lanes[i] ? drive_data[i*8 +: 8] : float_pat[i*8 +: 8];
  end
  always #5 clock = ~clock;
  always @(posedge clock) float_pat <= ~float_pat;
  task automatic summarize();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Bounded wait for ready or read pulse
  task automatic wait_hi(bit rd);
    int n;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while ((rd ? read_valid : request_ready) !== 1'b1 && n < 50);
    // Judge by the signal, so a hit on the last try still counts
    if ((rd ? read_valid : request_ready) !== 1'b1)
    begin
      $display("ERROR wait 1 0");
      failures++;
      summarize();
    end
  endtask
  // One request; stall freezes the block meanwhile
  task automatic xfer(logic wr, addr_type a, data_type d, byte_en_type b,
                      int stall);
    data_type m;
    m = {{8{b[1]}}, {8{b[0]}}};
    @(posedge clock);
    request_write <= wr;
    request_address <= a;
    request_data <= d;
    request_bytes <= b;
    request_valid <= 1'b1;
    wait_hi(0);
    request_valid <= 1'b0;
    // Only touch the enable when a stall is asked for
    if (stall > 0)
    begin
      clock_enable <= 1'b0;
      repeat (stall) @(posedge clock);
      clock_enable <= 1'b1;
    end
    if (wr)
      shadow[a] = (shadow[a] & ~m) | (d & m);
    else
    begin
      wait_hi(1);
      `CHECK("read_data", shadow[a] & m, read_data)
      // Read pulse must last a single cycle
      @(posedge clock);
      `CHECK("read_pulse", 1'b0, read_valid)
    end
  endtask
  task automatic t_reset();
    logic [6:0] pins;
    repeat (12) @(posedge clock);
    pins = {chip_select_n, write_strobe_n, output_drive_n, low_byte_sel_n,
      high_byte_sel_n, mem_data_oe, request_ready};
    `CHECK("idle", 7'h7c, pins)
    rst_n <= 1'b1;
    wait_hi(0);
    $display("reset test done");
  endtask
  task automatic t_words();
    xfer(1, 16'h0000, 16'ha55a, 2'h3, 0);
    xfer(1, 16'hffff, 16'h0ff0, 2'h3, 0);
    xfer(0, 16'h0000, 16'h0000, 2'h3, 0);
    xfer(0, 16'hffff, 16'h0000, 2'h3, 0);
    $display("word test done");
  endtask
  task automatic t_bytes();
    xfer(1, 16'h1234, 16'h1111, 2'h3, 0);
    xfer(1, 16'h1234, 16'hffaa, 2'h1, 0);
    xfer(1, 16'h1234, 16'hbbff, 2'h2, 0);
    for (int b = 1; b < 4; b++)
      xfer(0, 16'h1234, 16'h0000, b[1:0], 0);
    $display("byte test done");
  endtask
  // Empty lane mask is ignored; stalls freeze
  task automatic t_refuse();
    xfer(1, 16'h1234, 16'hdead, 2'h0, 0);
    // Refused request leaves the memory deselected and ready up
    repeat (3) @(posedge clock);
    `CHECK("refused", 3'h5, {chip_select_n, mem_data_oe, request_ready})
    xfer(0, 16'h1234, 16'h0000, 2'h3, 3);
    xfer(1, 16'h8000, 16'h7e81, 2'h3, 2);
    xfer(0, 16'h8000, 16'h0000, 2'h3, 0);
    $display("refuse test done");
  endtask
  initial
  begin
    t_reset();
    t_words();
    t_bytes();
    t_refuse();
    summarize();
  end
endmodule // sram_host_bench
